/* include/psp_pkg.sv */
// ==========================================
package psp_pkg;
    // ==========================================
    // register map, apb byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;     // mode, start command, stopped flag
    localparam logic [7:0] ADDR_TARGET = 8'h04;   // pulse target
    localparam logic [7:0] ADDR_SYSDLY = 8'h08;   // system delay in ms
    localparam logic [7:0] ADDR_SPEED = 8'h0c;    // present speed
    localparam logic [7:0] ADDR_MAXSPD = 8'h10;   // maximum speed
    localparam logic [7:0] ADDR_STATUS = 8'h14;   // state and stop request flag
    localparam logic [7:0] ADDR_COUNT = 8'h18;    // live pulse count
    localparam logic [7:0] ADDR_RAMPCNT = 8'h1c;  // pulses during ramp-down
    // ==========================================
    // field positions in control
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN_BIT = 4;
    localparam int CTRL_STOPPED_BIT = 5;
    // ==========================================
    // reset values and limits
    localparam logic [19:0] TARGET_MAX = 20'hf423f;    // 999999
    localparam logic [19:0] TARGET_RESET = 20'h186a0;  // 100000
    localparam logic [6:0] SYSDLY_MAX = 7'h64;         // 100 ms
    localparam logic [6:0] SYSDLY_RESET = 7'h0a;       // 10 ms
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [15:0] MAXSPD_RESET = 16'hffff;
    // ==========================================
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int PULSE_MAX_HZ_X10 = 676;            // 67.6 kHz in 100 Hz units
    // least pulse period, rounded down so a legal pulse is never refused
    localparam int PULSE_MIN_CYC = (CLK_HZ / 100) / PULSE_MAX_HZ_X10;
    // ==========================================
    // stop modes
    typedef enum logic [2:0]
    {
        PSP_RAMP = 3'h0,
        PSP_CNT_CLR = 3'h1,
        PSP_CNT_KEEP = 3'h2,
        PSP_COMP = 3'h3,
        PSP_COMP_CNT_CLR = 3'h4,
        PSP_COMP_CNT_KEEP = 3'h5
    } psp_mode_e;
    // controller states, one-hot
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_RUN = 5'h02,
        ST_DELAY = 5'h04,
        ST_RAMP = 5'h08,
        ST_DONE = 5'h10
    } psp_state_e;
    // configuration carried together
    typedef struct packed
    {
        logic [2:0] mode;
        logic [19:0] target;
        logic [6:0] sysdly;
        logic [15:0] speed;
        logic [15:0] maxspd;
    } psp_cfg_s;
endpackage : psp_pkg

/* design/psp_pulse_in.sv */
// ==========================================
// pulse input conditioning: sync, edge detect, rate guard
module psp_pulse_in
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin side
    input wire logic pulse_pin,
    // core side
    output logic pulse_seen
);
    logic sync_a;                   // first stage, read only by sync_b
    logic sync_b;                   // second stage
    logic prev;                     // last synced level
    logic [9:0] gap;                // cycles since last accepted edge
    // ==========================================
    // two-flop synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            sync_a <= pulse_pin;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end
    // ==========================================
    // rising edge accepted only past the least period; faster input is a sensor fault
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap <= 10'h3ff;
            pulse_seen <= 1'b0;
        end
        else
        begin
            pulse_seen <= 1'b0;
            if (gap != 10'h3ff)
            begin
                gap <= gap + 10'h001;
            end
            if (sync_b && !prev && gap >= 10'(psp_pkg::PULSE_MIN_CYC - 1))
            begin
                pulse_seen <= 1'b1;
                gap <= 10'h000;
            end
        end
    end
endmodule : psp_pulse_in

/* design/psp_stop_ctrl.sv */
// ==========================================
// precise stop controller with apb register access
module psp_stop_ctrl
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensor pin
    input wire logic pulse_pin,
    // ramp generator handshake
    input wire logic ramp_done,
    output logic stop_req
);
    psp_pkg::psp_cfg_s cfg;          // software configuration
    logic run_cmd;                   // start command from software
    logic run_prev;                  // for start edge
    psp_pkg::psp_state_e state;      // controller state
    logic pulse_seen;                // accepted sensor pulse
    logic ramp_done_s1;              // ramp_done sync stage 1
    logic ramp_done_s2;              // ramp_done sync stage 2
    logic [19:0] count;              // pulses since start edge
    logic [19:0] ramp_cnt;           // pulses during ramp-down
    logic [19:0] eff_target;         // target for this cycle
    logic [31:0] delay_cnt;          // compensation wait
    logic [31:0] next_delay;         // computed compensation
    logic apb_wr;                    // write access phase
    logic apb_rd;                    // read setup phase
    logic addr_ok;                   // mapped address
    logic is_count_mode;
    logic is_comp_mode;
    logic start_edge;
    logic stop_edge;

    // ==========================================
    // pulse conditioning
    psp_pulse_in u_pulse
    (
        .pclk(pclk),
        .presetn(presetn),
        .pulse_pin(pulse_pin),
        .pulse_seen(pulse_seen)
    );

    // ==========================================
    // mode decode
    always_comb
    begin
        is_count_mode = 1'b0;
        is_comp_mode = 1'b0;
        unique case (cfg.mode)
            psp_pkg::PSP_CNT_CLR, psp_pkg::PSP_CNT_KEEP: is_count_mode = 1'b1;
            psp_pkg::PSP_COMP: is_comp_mode = 1'b1;
            psp_pkg::PSP_COMP_CNT_CLR, psp_pkg::PSP_COMP_CNT_KEEP:
            begin
                is_count_mode = 1'b1;
                is_comp_mode = 1'b1;
            end
            default: ;                                                                    // plain ramp stop
        endcase
    end

    assign start_edge = run_cmd && !run_prev;
    assign stop_edge = !run_cmd && run_prev;

    // ==========================================
    // compensation delay: the distance after the stop command is constant when
    // the wait scales with (max - speed)/speed of the reference travel time.
    // reference travel uses the system delay; only its excess at low speed is waited.
    // a divider is costly, so a slow but exact combinational divide is accepted at 20 MHz.
    always_comb
    begin
        logic [47:0] num;
        logic [47:0] quo;
        logic [15:0] spd;
        num = 48'h0;
        quo = 48'h0;
        spd = cfg.speed;
        next_delay = 32'h0;
        if (is_comp_mode && spd != 16'h0 && spd < cfg.maxspd)
        begin
            // wait = sysdly * (max - spd) / spd milliseconds, in cycles
            num = 48'(cfg.sysdly) * 48'(cfg.maxspd - spd) * 48'(psp_pkg::CYC_PER_MS);
            quo = num / 48'(spd);
            // a very slow motor with a long delay saturates rather than wrapping to a short wait
            next_delay = (quo[47:32] != 16'h0) ? 32'hffffffff : quo[31:0];
        end
    end

    // ==========================================
    // stop state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= psp_pkg::ST_IDLE;
            delay_cnt <= 32'h0;
            stop_req <= 1'b0;
            run_prev <= 1'b0;
        end
        else
        begin
            run_prev <= run_cmd;
            unique case (state)
                psp_pkg::ST_IDLE:
                begin
                    stop_req <= 1'b0;
                    if (start_edge)
                    begin
                        state <= psp_pkg::ST_RUN;
                    end
                end
                psp_pkg::ST_RUN:
                begin
                    if (is_count_mode && count >= eff_target)
                    begin
                        stop_req <= 1'b1;
                        state <= psp_pkg::ST_RAMP;
                    end
                    else if (stop_edge)
                    begin
                        if (next_delay != 32'h0)
                        begin
                            delay_cnt <= next_delay;
                            state <= psp_pkg::ST_DELAY;
                        end
                        else
                        begin
                            stop_req <= 1'b1;
                            state <= psp_pkg::ST_RAMP;
                        end
                    end
                end
                psp_pkg::ST_DELAY:
                begin
                    delay_cnt <= delay_cnt - 32'h1;
                    if (delay_cnt <= 32'h1)
                    begin
                        stop_req <= 1'b1;
                        state <= psp_pkg::ST_RAMP;
                    end
                end
                psp_pkg::ST_RAMP:
                begin
                    if (ramp_done_s2)
                    begin
                        stop_req <= 1'b0;
                        state <= psp_pkg::ST_DONE;
                    end
                end
                psp_pkg::ST_DONE:
                begin
                    state <= psp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // ramp_done comes from the drive's ramp logic, treated as asynchronous
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_done_s1 <= 1'b0;
            ramp_done_s2 <= 1'b0;
        end
        else
        begin
            ramp_done_s1 <= ramp_done;
            ramp_done_s2 <= ramp_done_s1;
        end
    end

    // ==========================================
    // pulse counters and target bookkeeping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 20'h0;
            ramp_cnt <= 20'h0;
            eff_target <= psp_pkg::TARGET_RESET;
        end
        else
        begin
            if (state == psp_pkg::ST_IDLE && start_edge)
            begin
                count <= 20'h0;
                ramp_cnt <= 20'h0;
                // target taken at each start, so one written while idle counts at once;
                // in keeping modes the carried overrun eats into it, floored at zero
                if (cfg.mode == psp_pkg::PSP_CNT_KEEP || cfg.mode == psp_pkg::PSP_COMP_CNT_KEEP)
                begin
                    eff_target <= (ramp_cnt >= cfg.target) ? 20'h0 : cfg.target - ramp_cnt;
                end
                else
                begin
                    eff_target <= cfg.target;
                end
            end
            else if ((state == psp_pkg::ST_RUN || state == psp_pkg::ST_DELAY) && pulse_seen)
            begin
                count <= count + 20'h1;
            end
            else if (state == psp_pkg::ST_RAMP && pulse_seen)
            begin
                ramp_cnt <= ramp_cnt + 20'h1;
            end
            // clearing modes drop the ramp pulses; keeping modes carry them to the next start
            if (state == psp_pkg::ST_DONE && cfg.mode != psp_pkg::PSP_CNT_KEEP
                && cfg.mode != psp_pkg::PSP_COMP_CNT_KEEP)
            begin
                ramp_cnt <= 20'h0;
            end
        end
    end

    // ==========================================
    // apb decode; zero wait states
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    always_comb
    begin
        unique case (paddr)
            psp_pkg::ADDR_CTRL, psp_pkg::ADDR_TARGET, psp_pkg::ADDR_SYSDLY, psp_pkg::ADDR_SPEED,
            psp_pkg::ADDR_MAXSPD, psp_pkg::ADDR_STATUS, psp_pkg::ADDR_COUNT,
            psp_pkg::ADDR_RAMPCNT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ==========================================
    // register writes; out-of-range target and delay are clamped, bad mode codes fall back
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg.mode <= psp_pkg::PSP_RAMP;
            cfg.target <= psp_pkg::TARGET_RESET;
            cfg.sysdly <= psp_pkg::SYSDLY_RESET;
            cfg.speed <= psp_pkg::SPEED_RESET;
            cfg.maxspd <= psp_pkg::MAXSPD_RESET;
            run_cmd <= 1'b0;
        end
        else if (apb_wr)
        begin
            unique case (paddr)
                psp_pkg::ADDR_CTRL:
                begin
                    // codes 6 and 7 are illegal and fall back to plain ramp stop
                    cfg.mode <= (pwdata[2:0] > 3'h5) ? psp_pkg::PSP_RAMP : pwdata[2:0];
                    run_cmd <= pwdata[psp_pkg::CTRL_RUN_BIT];
                end
                psp_pkg::ADDR_TARGET:
                    cfg.target <= (pwdata[31:20] != 12'h0 || pwdata[19:0] > psp_pkg::TARGET_MAX)
                        ? psp_pkg::TARGET_MAX : pwdata[19:0];
                psp_pkg::ADDR_SYSDLY:
                    cfg.sysdly <= (pwdata[31:7] != 25'h0 || pwdata[6:0] > psp_pkg::SYSDLY_MAX)
                        ? psp_pkg::SYSDLY_MAX : pwdata[6:0];
                psp_pkg::ADDR_SPEED: cfg.speed <= pwdata[15:0];
                psp_pkg::ADDR_MAXSPD: cfg.maxspd <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // read data latched in setup so it is registered in access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (apb_rd)
            begin
                unique case (paddr)
                    psp_pkg::ADDR_CTRL: prdata <= {26'h0, (state == psp_pkg::ST_IDLE), run_cmd, 1'b0, cfg.mode};
                    psp_pkg::ADDR_TARGET: prdata <= {12'h0, cfg.target};
                    psp_pkg::ADDR_SYSDLY: prdata <= {25'h0, cfg.sysdly};
                    psp_pkg::ADDR_SPEED: prdata <= {16'h0, cfg.speed};
                    psp_pkg::ADDR_MAXSPD: prdata <= {16'h0, cfg.maxspd};
                    psp_pkg::ADDR_STATUS: prdata <= {26'h0, stop_req, state};
                    psp_pkg::ADDR_COUNT: prdata <= {12'h0, count};
                    psp_pkg::ADDR_RAMPCNT: prdata <= {12'h0, ramp_cnt};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule : psp_stop_ctrl

/* tb/psp_stop_ctrl_assertions.sv */
// ==========================================
// port checker for the stop controller
module psp_stop_ctrl_assertions
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sensor and ramp side
    input wire logic pulse_pin,
    input wire logic ramp_done,
    input wire logic stop_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================
    // shadow of accepted settings
    logic run_q; // last run command
    logic [15:0] spd_q; // last present speed
    logic [15:0] max_q; // last maximum speed
    logic [6:0] dly_q; // last system delay, unclamped
    logic acc; // transfer completes at this edge
    logic wr_ctrl; // control write completes
    logic rd_acc; // read data handed over
    assign acc = psel && penable && pready;
    assign wr_ctrl = acc && pwrite && paddr == psp_pkg::ADDR_CTRL;
    assign rd_acc = acc && !pwrite;
    // follows writes only, refused ones leave it alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= 1'b0;
            spd_q <= psp_pkg::SPEED_RESET;
            max_q <= psp_pkg::MAXSPD_RESET;
            dly_q <= psp_pkg::SYSDLY_RESET;
        end
        else if (acc && pwrite && !pslverr)
        begin
            if (paddr == psp_pkg::ADDR_CTRL) run_q <= pwdata[4];
            if (paddr == psp_pkg::ADDR_SPEED) spd_q <= pwdata[15:0];
            if (paddr == psp_pkg::ADDR_MAXSPD) max_q <= pwdata[15:0];
            if (paddr == psp_pkg::ADDR_SYSDLY) dly_q <= pwdata[6:0];
        end
    end
    // ==========================================
    // properties
    property p_apb_ready;
        psel && penable |-> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("access cycle without ready");
    property p_err_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error outside an access");
    property p_mode_range;
        rd_acc && paddr == psp_pkg::ADDR_CTRL |-> prdata[2:0] <= 3'h5;
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("stop mode out of range");
    property p_target_range;
        rd_acc && paddr == psp_pkg::ADDR_TARGET |-> prdata <= 32'(psp_pkg::TARGET_MAX);
    endproperty
    a_target_range: assert property (p_target_range) else $error("pulse target too big");
    property p_sysdly_range;
        rd_acc && paddr == psp_pkg::ADDR_SYSDLY |-> prdata <= 32'(psp_pkg::SYSDLY_MAX);
    endproperty
    a_sysdly_range: assert property (p_sysdly_range) else $error("system delay too big");
    // stop stays up until standstill has had time to pass the sync
    property p_stop_hold;
        stop_req && !ramp_done && !$past(ramp_done) && !$past(ramp_done, 2) |=> stop_req;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop dropped early");
    property p_stop_release;
        $rose(ramp_done) |-> ##[1:6] !stop_req;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop kept after standstill");
    property p_plain_stop;
        wr_ctrl && run_q && !pwdata[4] && pwdata[2:0] == 3'h0 |-> ##[1:3] stop_req;
    endproperty
    a_plain_stop: assert property (p_plain_stop) else $error("plain stop not issued");
    // half speed or less with a delay set must hold the stop back
    property p_comp_delay;
        wr_ctrl && run_q && !pwdata[4] && pwdata[2:0] == 3'h3 && dly_q != 7'h00 && spd_q != 16'h0000
            && {spd_q, 1'b0} <= {1'b0, max_q} |=> !stop_req [*8];
    endproperty
    a_comp_delay: assert property (p_comp_delay) else $error("slow stop not delayed");
    c_start: cover property (wr_ctrl && pwdata[4]);
    c_stop: cover property ($rose(stop_req));
    c_standstill: cover property ($rose(ramp_done));
    c_refused: cover property (pslverr);
endmodule : psp_stop_ctrl_assertions

bind psp_stop_ctrl psp_stop_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_pin(pulse_pin), .ramp_done(ramp_done), .stop_req(stop_req));

/* tb/psp_sensor_model.sv */
// ==========================================
// pulse sensor and ramp generator stand-in
module psp_sensor_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // from the controller
    input wire logic stop_req,
    // sensor and ramp side
    output logic pulse_pin,
    output logic ramp_done
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE_HALF = 150; // 301-cycle period (150 high, 151 low), below the top rate
    int pend = 0; // pulses still to send
    int ramp_n = 0; // pulses that arrive during ramp-down
    int ramp_wait = 20; // ramp length before the pulses, slow answers use more
    initial
    begin
        pulse_pin = 1'b0;
        ramp_done = 1'b0;
    end
    // ==========================================
    // pulse train, one whole period per pulse
    always
    begin
        @(posedge pclk);
        if (pend > 0)
        begin
            pulse_pin <= 1'b1;
            repeat (PULSE_HALF) @(posedge pclk);
            pulse_pin <= 1'b0;
            repeat (PULSE_HALF) @(posedge pclk);
            pend = pend - 1;
        end
    end
    // ==========================================
    // ramp-down: motor keeps moving, then standstill held until stop drops
    always
    begin
        @(posedge pclk);
        if (stop_req === 1'b1 && ramp_done === 1'b0)
        begin
            // the pulse in flight ends first, so the bench's own pulse wait is not stretched
            for (int i = 0; i < 4000 && pend > 0; i++) @(posedge pclk);
            repeat (ramp_wait) @(posedge pclk);
            pend = pend + ramp_n;
            for (int j = 0; j < 4000 && pend > 0; j++) @(posedge pclk);
            ramp_done <= 1'b1;
        end
        else if (stop_req !== 1'b1)
            ramp_done <= 1'b0;
    end
endmodule : psp_sensor_model

/* tb/precise_stop_pulse_counter_tb.sv */
// ==========================================
// bench for the precise stop controller
module precise_stop_pulse_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0; // 20 MHz
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pulse_pin, ramp_done, stop_req;
    int num_errors = 0;
    int tests_run = 0;
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t got %h expected %h", $time, (got), (exp)); end end
    always #25 pclk = ~pclk;
    psp_stop_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_pin(pulse_pin), .ramp_done(ramp_done), .stop_req(stop_req));
    psp_sensor_model u_sens (.pclk(pclk), .presetn(presetn), .stop_req(stop_req), .pulse_pin(pulse_pin),
        .ramp_done(ramp_done));
    // ==========================================
    // verdict, also the end of any hang
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    // one apb transfer, request held until ready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20) `CHK(pready, 1'b1)
        if (n >= 20) results();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
    endtask : wr
    task automatic rdv(input logic [7:0] a, output logic [31:0] v);
        logic err;
        apb(a, 1'b0, 32'h0, v, err);
    endtask : rdv
    // bounded wait for the stop line
    task automatic wait_stop(input logic v, input int bound);
        int n;
        n = 0;
        while (stop_req !== v && n < bound)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(stop_req, v)
        if (stop_req !== v) results();
    endtask : wait_stop
    // send pulses and wait until the last period ends
    task automatic pulses(input int k);
        int n;
        n = 0;
        u_sens.pend = k;
        while (u_sens.pend > 0 && n < k * 400 + 50)
        begin
            @(posedge pclk);
            n++;
        end
        if (u_sens.pend > 0) `CHK(u_sens.pend, 0)
        if (u_sens.pend > 0) results();
    endtask : pulses
    // ==========================================
    // reset values, clamps, unmapped place, mode codes
    task automatic t_regs();
        logic [31:0] v;
        logic e;
        rdv(psp_pkg::ADDR_TARGET, v);
        `CHK(v, 32'(psp_pkg::TARGET_RESET))
        rdv(psp_pkg::ADDR_SYSDLY, v);
        `CHK(v, 32'(psp_pkg::SYSDLY_RESET))
        apb(8'h20, 1'b0, 32'h0, v, e);
        `CHK(e, 1'b1)
        wr(psp_pkg::ADDR_TARGET, 32'hfffff);
        rdv(psp_pkg::ADDR_TARGET, v);
        `CHK(v, 32'(psp_pkg::TARGET_MAX))
        wr(psp_pkg::ADDR_SYSDLY, 32'h7f);
        rdv(psp_pkg::ADDR_SYSDLY, v);
        `CHK(v, 32'(psp_pkg::SYSDLY_MAX))
        for (int m = 0; m < 8; m++)
        begin
            wr(psp_pkg::ADDR_CTRL, 32'(m));
            rdv(psp_pkg::ADDR_CTRL, v);
            `CHK(v[2:0], (m <= 5) ? 3'(m) : 3'h0)
        end
        $display("test registers done");
    endtask : t_regs
    // two counted cycles; the second needs need pulses after ramp pulses
    task automatic t_count(input logic [2:0] md, input int tgt, input int ramp, input int need);
        wr(psp_pkg::ADDR_TARGET, 32'(tgt));
        u_sens.ramp_n = ramp;
        for (int c = 0; c < 2; c++)
        begin
            wr(psp_pkg::ADDR_CTRL, 32'(md));
            wr(psp_pkg::ADDR_CTRL, 32'(md) | 32'h10); // count starts at this edge
            pulses(((c == 0) ? tgt : need) - 1);
            `CHK(stop_req, 1'b0)
            pulses(1);
            wait_stop(1'b1, 10);
            wait_stop(1'b0, 5000);
            u_sens.ramp_n = 0;
        end
        wr(psp_pkg::ADDR_CTRL, 32'(md));
        $display("test counted mode %0d done", md);
    endtask : t_count
    // stop command, stop expected after lo cycles and within lo plus hi
    task automatic t_stop(input logic [2:0] md, input logic [15:0] spd, input logic [15:0] mx, input int lo,
        input int hi);
        wr(psp_pkg::ADDR_SPEED, 32'(spd));
        wr(psp_pkg::ADDR_MAXSPD, 32'(mx));
        wr(psp_pkg::ADDR_CTRL, 32'(md) | 32'h10);
        wr(psp_pkg::ADDR_CTRL, 32'(md));
        repeat (lo) @(posedge pclk);
        if (lo > 0) `CHK(stop_req, 1'b0)
        wait_stop(1'b1, hi);
        wait_stop(1'b0, 5000);
        $display("test stop mode %0d done", md);
    endtask : t_stop
    // ==========================================
    // main sequence; sensor pulses are sent only in the counted stop modes
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        wr(psp_pkg::ADDR_SPEED, 32'hffff);
        t_count(3'h1, 3, 2, 3);
        t_count(3'h2, 3, 1, 2);
        t_count(3'h4, 2, 1, 2);
        u_sens.ramp_wait = 600;
        t_count(3'h5, 3, 1, 2);
        u_sens.ramp_wait = 20;
        t_stop(3'h0, 16'h0001, 16'h0002, 0, 4);
        t_stop(3'h3, 16'h0002, 16'h0002, 0, 4);
        wr(psp_pkg::ADDR_SYSDLY, 32'h1);
        t_stop(3'h3, 16'h0001, 16'h0002, 19000, 2000);
        results();
    end
endmodule : precise_stop_pulse_counter_tb
